// File: core/fir_regs.v
// Purpose: identification and start address register bank on avalon-mm
// Assumes: one 20 MHz clock, async active-high reset, 16-bit data in low bits
// Notes: answers every access one cycle after it is presented
`timescale 1ns/1ps
`default_nettype none
`include "fir_consts.vh"

module fir_regs #(
  parameter [1:0] SUPPLY_CLASS = `FIR_SUPPLY_LOW,
  parameter [0:0] SEPARATE_BUS = `FIR_BUS_MUXED,
  parameter [0:0] DUAL_DIE = `FIR_DIE_SINGLE,
  parameter [3:0] DENSITY = `FIR_DENSITY_256M,
  parameter [0:0] TOP_BOOT = `FIR_BOOT_BOTTOM,
  // version contents: arbitrary value
  parameter [15:0] VERSION_CODE = `FIR_VERSION_CODE
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // avalon-mm slave
  input wire [17:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  output reg [1:0] response,
  // address fields to the operation logic
  output reg [8:0] source_block,
  output reg [5:0] source_page,
  output reg source_sector,
  output reg [8:0] dest_block,
  output reg [5:0] dest_page,
  output reg dest_sector
);

  reg done;
  wire [15:0] index;
  wire lo_en;
  wire hi_en;
  wire wr_now;
  reg [15:0] rd_word;
  reg hit;

  // word index from byte address; map lives at index*4
  assign index = address[17:2];
  assign lo_en = byteenable[0];
  assign hi_en = byteenable[1];
  // one wait cycle, then the access completes
  assign waitrequest = (read | write) & ~done;
  assign wr_now = write & done;

  // part code composed from straps
  function [15:0] fir_part_code;
    input dummy;
    begin
      fir_part_code = {7'h00, TOP_BOOT, DENSITY, DUAL_DIE, SEPARATE_BUS,
                       SUPPLY_CLASS};
    end
  endfunction

  // decode of read value and whether the index is mapped
  always @* begin
    rd_word = `FIR_ZERO16;
    hit = 1'b1;
    case (index)
      `FIR_IDX_PART_CODE: rd_word = fir_part_code(1'b0);
      `FIR_IDX_VERSION: rd_word = VERSION_CODE;
      `FIR_IDX_DATA_WORDS: rd_word = `FIR_DATA_WORDS;
      `FIR_IDX_BOOT_WORDS: rd_word = `FIR_BOOT_WORDS;
      `FIR_IDX_BUF_COUNT: rd_word = `FIR_BUF_COUNT;
      `FIR_IDX_TECH: rd_word = `FIR_TECH_SLC;
      `FIR_IDX_SRC_BLOCK: rd_word = {7'h00, source_block};
      `FIR_IDX_DEST_BLOCK: rd_word = {7'h00, dest_block};
      `FIR_IDX_DEST_PAGE: rd_word = {8'h00, dest_page, 1'b0,
                                     dest_sector};
      `FIR_IDX_SRC_PAGE: rd_word = {8'h00, source_page, 1'b0,
                                    source_sector};
      // reserved locations accept the access and read zero
      `FIR_IDX_SPARE_TWO, `FIR_IDX_SPARE_FIVE,
      `FIR_IDX_SPARE_SIX, `FIR_IDX_SPARE_SEVEN: rd_word = `FIR_ZERO16;
      default: hit = 1'b0;
    endcase
  end

  // handshake: done pulses on the second cycle of each access
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
      readdata <= `FIR_ZERO32;
      response <= `FIR_RESP_OKAY;
    end else begin
      done <= (read | write) & ~done;
      if (read & ~done) begin
        readdata <= {`FIR_ZERO16, rd_word};
        // unmapped address answers decode error with zero data
        response <= hit ? `FIR_RESP_OKAY : `FIR_RESP_DECODE;
      end else if (write & ~done) begin
        response <= hit ? `FIR_RESP_OKAY : `FIR_RESP_DECODE;
      end
    end
  end

  // writable address fields; read-only indices fall through untouched
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      source_block <= `FIR_RESET_BLOCK;
      source_page <= `FIR_RESET_PAGE;
      source_sector <= `FIR_RESET_SECTOR;
      dest_block <= `FIR_RESET_BLOCK;
      dest_page <= `FIR_RESET_PAGE;
      dest_sector <= `FIR_RESET_SECTOR;
    end else if (wr_now) begin
      case (index)
        `FIR_IDX_SRC_BLOCK: begin
          if (lo_en) source_block[7:0] <= writedata[7:0];
          if (hi_en) source_block[8] <= writedata[8];
        end
        `FIR_IDX_DEST_BLOCK: begin
          if (lo_en) dest_block[7:0] <= writedata[7:0];
          if (hi_en) dest_block[8] <= writedata[8];
        end
        `FIR_IDX_DEST_PAGE: begin
          if (lo_en) begin
            dest_page <= writedata[`FIR_PAGE_MSB:`FIR_PAGE_LSB];
            dest_sector <= writedata[`FIR_SECTOR_BIT];
          end
        end
        `FIR_IDX_SRC_PAGE: begin
          if (lo_en) begin
            source_page <= writedata[`FIR_PAGE_MSB:`FIR_PAGE_LSB];
            source_sector <= writedata[`FIR_SECTOR_BIT];
          end
        end
        default: ;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: core/fir_consts.vh
// Purpose: constants for the flash identification and start address bank
// Assumes: word-indexed register map, avalon byte address is index times four
// Notes: identification fields are straps of the part, values arbitrary
//
// Overview of operation
// - id bits 1:0 give the supply class, 00 low voltage, 01 higher voltage.
// - id bit 2 is 0 for muxed bus, 1 for separate; bit 3 is 1 for dual die.
// - id bits 7:4 give density, 0000 for 128 Mb doubling up to 0101 for 4 Gb.
// - id bit 8 reads 0 for bottom boot area and 1 for top boot area.
// - the data buffer size register reads 0400h, two buffers of 512 words.
// - the boot buffer size register reads 0200h, one buffer of 512 words.
// - the buffer count register reads 0201h, two data and one boot buffer.
// - the technology register reads 0000h for slc, this part returns 0000h.
// - source block register holds a 9-bit block in bits 8:0, reset zero.
// - destination block register holds a 9-bit copy-back target block.
// - destination page in bits 7:2, sector in bit 0, bit 1 reserved, reset 0.
// - source page in bits 7:2 and source sector in bit 0, both reset zero.
// - start address locations two, five, six and seven are reserved.
// - the version location is reserved and holds nothing to rely on.
`ifndef FIR_CONSTS_VH
`define FIR_CONSTS_VH

// register indices (word order)
`define FIR_IDX_PART_CODE 16'hf001
`define FIR_IDX_VERSION 16'hf002
`define FIR_IDX_DATA_WORDS 16'hf003
`define FIR_IDX_BOOT_WORDS 16'hf004
`define FIR_IDX_BUF_COUNT 16'hf005
`define FIR_IDX_TECH 16'hf006
`define FIR_IDX_SRC_BLOCK 16'hf100
`define FIR_IDX_SPARE_TWO 16'hf101
`define FIR_IDX_DEST_BLOCK 16'hf102
`define FIR_IDX_DEST_PAGE 16'hf103
`define FIR_IDX_SPARE_FIVE 16'hf104
`define FIR_IDX_SPARE_SIX 16'hf105
`define FIR_IDX_SPARE_SEVEN 16'hf106
`define FIR_IDX_SRC_PAGE 16'hf107

// fixed read values
`define FIR_DATA_WORDS 16'h0400
`define FIR_BOOT_WORDS 16'h0200
`define FIR_BUF_COUNT 16'h0201
`define FIR_TECH_SLC 16'h0000
`define FIR_TECH_MLC 16'h0001
`define FIR_ZERO16 16'h0000
`define FIR_ZERO32 32'h0000_0000
`define FIR_RESP_OKAY 2'h0
`define FIR_RESP_DECODE 2'h3

// field layout
`define FIR_BLOCK_W 9
`define FIR_PAGE_W 6
`define FIR_PAGE_LSB 2
`define FIR_PAGE_MSB 7
`define FIR_SECTOR_BIT 0
`define FIR_RESET_BLOCK 9'h000
`define FIR_RESET_PAGE 6'h00
`define FIR_RESET_SECTOR 1'b0

// part code straps: supply, bus, die, density, boot location
`define FIR_SUPPLY_LOW 2'h0
`define FIR_SUPPLY_HIGH 2'h1
`define FIR_BUS_MUXED 1'b0
`define FIR_DIE_SINGLE 1'b0
`define FIR_DENSITY_256M 4'h1
`define FIR_BOOT_BOTTOM 1'b0
`define FIR_VERSION_CODE 16'h0000

`endif

// File: verification/fir_regs_properties.sv
// Purpose: port checks for fir_regs
// Assumes: writes use both low byte lanes
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module fir_regs_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic [17:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // fields
  input wire logic [8:0] source_block,
  input wire logic [5:0] source_page,
  input wire logic [8:0] dest_block,
  input wire logic [5:0] dest_page
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // accepted accesses and their word index
  wire logic [15:0] idx = address[17:2];
  wire logic wr_ok = write && !waitrequest;
  wire logic rd_ok = read && !waitrequest;
  a_one_wait: assert property ((read || write) && waitrequest |=>
    !waitrequest) else $error("no answer");
  a_src_block: assert property (wr_ok && idx == 16'hf100 |=>
    source_block == $past(writedata[8:0])) else $error("block");
  a_dst_block: assert property (wr_ok && idx == 16'hf102 |=>
    dest_block == $past(writedata[8:0])) else $error("dest");
  a_dst_page: assert property (wr_ok && idx == 16'hf103 |=>
    dest_page == $past(writedata[7:2])) else $error("dest page");
  a_src_page: assert property (wr_ok && idx == 16'hf107 |=>
    source_page == $past(writedata[7:2])) else $error("page");
  a_data_size: assert property (rd_ok && idx == 16'hf003 |->
    readdata == 32'h0000_0400) else $error("data size");
  a_boot_size: assert property (rd_ok && idx == 16'hf004 |->
    readdata == 32'h0000_0200) else $error("boot size");
  a_buf_count: assert property (rd_ok && idx == 16'hf005 |->
    readdata == 32'h0000_0201) else $error("count");
  a_tech_slc: assert property (rd_ok && idx == 16'hf006 |->
    readdata == 32'h0000_0000) else $error("tech");
endmodule
`default_nettype wire

// File: verification/fir_host.sv
// Purpose: avalon-mm host model for fir_regs
// Assumes: xfer is entered just after a rising edge
// Notes: released data is inverted so stale use shows
`timescale 1ns/1ps
`default_nettype none
module fir_host (
  // clock
  input wire logic clk,
  // master side
  output var logic [17:0] address,
  output var logic read,
  output var logic write,
  output var logic [31:0] writedata,
  output var logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response
);
  // idle bus from time zero
  initial begin
    {address, read, write} = 20'h0_0000;
    writedata = 32'h0000_0000;
    byteenable = 4'h3;
  end
  // request held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [15:0] ix,
    input logic [15:0] wd, output logic [31:0] rd, output logic [1:0] rs);
    address <= {ix, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {16'h0000, wd};
    @(posedge clk);
    while (waitrequest) @(posedge clk);
    rd = readdata;
    rs = response;
    {read, write} <= 2'b00;
    writedata <= ~writedata;
    // one idle edge, so a following call never reassigns in this time step
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: verification/fir_regs_tb.sv
// Purpose: self-checking bench for fir_regs
// Assumes: 20 MHz clock, reset held six cycles
// Notes: part code straps set away from defaults
`timescale 1ns/1ps
`default_nettype none
module fir_regs_tb;
  logic clk, rst, read, write, waitrequest;
  logic [17:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic [1:0] response, rs;
  logic [8:0] source_block, dest_block;
  logic [5:0] source_page, dest_page;
  logic source_sector, dest_sector;
  int fail_count = 0, num_checks = 0, cycles = 0;
  logic [15:0] ix [14] = '{16'hf001, 16'hf003, 16'hf004, 16'hf005, 16'hf006,
    16'hf101, 16'hf104, 16'hf105, 16'hf106, 16'hf010,
    16'hf100, 16'hf102, 16'hf103, 16'hf107};
  logic [17:0] ex [14] = '{18'h0_015d, 18'h0_0400, 18'h0_0200, 18'h0_0201,
    0, 0, 0, 0, 0, 18'h3_0000, 0, 0, 0, 0};
  logic [15:0] mk [4] = '{16'h01ff, 16'h01ff, 16'h00fd, 16'h00fd};
  fir_regs #(.SUPPLY_CLASS(2'h1), .SEPARATE_BUS(1'b1), .DUAL_DIE(1'b1),
    .DENSITY(4'h5), .TOP_BOOT(1'b1)) dut_u (.clk, .rst, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .response,
    .source_block, .source_page, .source_sector, .dest_block, .dest_page,
    .dest_sector);
  fir_host host_u (.clk, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .response);
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, far above the roughly 180 cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [33:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // fixed, reserved and unmapped places; writes there must not stick
  task automatic t_fixed(input logic wr_first);
    for (int i = 0; i < 14; i++) begin
      if (wr_first && i < 10) host_u.xfer(1'b1, ix[i], 16'hffff, rd, rs);
      host_u.xfer(1'b0, ix[i], 16'h0000, rd, rs);
      check("read", {rs, rd}, {ex[i][17:16], 16'h0000, ex[i][15:0]});
    end
    $display("t_fixed %0d done", wr_first);
  endtask
  // address registers back to back: fields kept, reserved bits zero
  task automatic t_addr(input logic [15:0] p);
    for (int i = 10; i < 14; i++) host_u.xfer(1'b1, ix[i], p, rd, rs);
    for (int i = 10; i < 14; i++) begin
      host_u.xfer(1'b0, ix[i], 16'h0000, rd, rs);
      check("addr", rd, {16'h0000, p & mk[i - 10]});
    end
    check("fields", {source_block, dest_block, source_page, dest_page,
      source_sector, dest_sector}, {p[8:0], p[8:0], p[7:2], p[7:2], p[0], p[0]});
    $display("t_addr %h done", p);
  endtask
  // reset in mid-run returns a written block address to zero
  task automatic t_reset();
    host_u.xfer(1'b1, 16'hf100, 16'h0123, rd, rs);
    check("pre block", source_block, 9'h123);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("rst block", source_block, 9'h000);
    host_u.xfer(1'b0, 16'hf100, 16'h0000, rd, rs);
    check("rst read", rd, 32'h0000_0000);
    $display("t_reset done");
  endtask
  initial begin
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_fixed(1'b0);
    t_fixed(1'b1);
    t_addr(16'hffff);
    t_addr(16'haaaa);
    t_reset();
    summarize();
  end
endmodule
bind fir_regs fir_regs_properties chk_u (.clk, .rst, .address, .read,
  .write, .writedata, .readdata, .waitrequest, .source_block, .source_page,
  .dest_block, .dest_page);
`default_nettype wire
